// ---- core/pcdc_div.sv ----
// Toggle divider stepped by prescaled source ticks.
// Assumes tick is a one-cycle pulse and clear holds it at its start.
`timescale 1ns/1ps
module pcdc_div
    import pcdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Divider carrier
    pcdc_div_if.div dv
);
    pcdc_half_type cnt_r;
    logic level_r;

    // Count of zero at clear makes the first tick a rising edge
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 8'h00;
        end else if (dv.clear) begin
            cnt_r <= 8'h00;
        end else if (dv.tick) begin
            cnt_r <= (cnt_r == 8'h00) ? dv.half - 8'h01 : cnt_r - 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_r <= 1'b0;
        end else if (dv.clear) begin
            level_r <= 1'b0;
        end else if (dv.tick && cnt_r == 8'h00) begin
            level_r <= ~level_r;
        end
    end

    assign dv.level = level_r;
    assign dv.rise = dv.tick & (cnt_r == 8'h00) & ~level_r;
endmodule

// ---- core/pcdc_div_if.sv ----
// Carrier between the control logic, one divider and the sync monitor.
// Assumes one clock domain; tick is a single-cycle pulse, clear a held level.
`timescale 1ns/1ps
interface pcdc_div_if;
    import pcdc_pkg::*;
    logic tick;
    logic clear;
    pcdc_half_type half;
    logic level;
    logic rise;
    modport ctl (output tick, output clear, output half,
                 input level, input rise);
    modport div (input tick, input clear, input half,
                 output level, output rise);
    modport mon (input level, input rise);
endinterface

// ---- core/pcdc_pkg.sv ----
// Constants and types for the PLL clock divider control block.
// Assumes a 32-bit AHB-Lite slave decoding the low address byte.
package pcdc_pkg;

    typedef logic [1:0] pcdc_cfg_type;
    typedef logic [7:0] pcdc_half_type;
    typedef logic [2:0] pcdc_period_type;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COINC_COUNT = 8'h08;

    // Control register fields
    localparam int CTRL_REF_SEL_BIT = 0;
    localparam int CTRL_VCO_RANGE_BIT = 1;
    localparam int CTRL_LOOP_EN_BIT = 2;
    localparam int CTRL_STOP_BIT = 3;
    localparam int CTRL_CFG_LSB = 4;
    localparam logic [31:0] CTRL_MASK = 32'h0000_003f;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0007;

    // Status register fields
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_A_BIT = 1;
    localparam int STAT_B_BIT = 2;
    localparam int STAT_SYNC_BIT = 3;
    localparam int STAT_FB_BIT = 4;
    localparam int STAT_REF_BIT = 5;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Prescaler terminal counts: range 0 divides by 2, range 1 by 4
    localparam logic [1:0] PRE_LAST_RANGE0 = 2'h1;
    localparam logic [1:0] PRE_LAST_RANGE1 = 2'h3;

    // Half periods after prescale, index {bit0, bit1}
    localparam pcdc_half_type HALF_A [0:3] = '{8'h02, 8'h01, 8'h02, 8'h01};
    localparam pcdc_half_type HALF_B [0:3] = '{8'h03, 8'h02, 8'h05, 8'h03};
    localparam pcdc_half_type HALF_FB [0:3] = '{8'h0c, 8'h08, 8'h14, 8'h0c};
    // Bank A periods between coincident edges
    localparam pcdc_period_type SYNC_PERIODS [0:3] =
        '{3'h3, 3'h2, 3'h5, 3'h3};

endpackage

// ---- core/pcdc_sync.sv ----
// Coincidence monitor for the bank A and bank B dividers.
// Assumes both dividers share ticks and were cleared together.
`timescale 1ns/1ps
module pcdc_sync
    import pcdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Monitored banks
    pcdc_div_if.mon bank_a,
    pcdc_div_if.mon bank_b,
    // Control
    input wire logic clear_i,
    input wire pcdc_period_type period_i,
    // Result
    output logic sync_o,
    output logic coinc_o
);
    pcdc_period_type cnt_r;
    pcdc_period_type cnt_nxt;
    logic sync_r;

    // Coincident rise restarts the count, so a config change recovers
    always_comb begin
        cnt_nxt = bank_b.rise ? 3'h0 : cnt_r + 3'h1;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 3'h0;
        end else if (clear_i) begin
            cnt_r <= 3'h0;
        end else if (bank_a.rise) begin
            cnt_r <= cnt_nxt;
        end
    end

    // High over the last bank A period before each coincidence
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_r <= 1'b0;
        end else if (clear_i) begin
            sync_r <= 1'b0;
        end else if (bank_a.rise) begin
            sync_r <= (cnt_nxt == period_i - 3'h1);
        end
    end

    assign sync_o = sync_r;
    assign coinc_o = bank_a.rise & bank_b.rise;
endmodule

// ---- core/pcdc_top.sv ----
// PLL clock divider control: source select, prescale, bank dividers,
// sync generation and an AHB-Lite register slave.
// Assumes all pin inputs synchronous to clk_sys_i and at most a quarter
// of its rate; the analog VCO output arrives on vco_clk_i.
//
// Operation
// - Reference select 0 takes the differential pair, 1 the crystal.
// - VCO range 0 scales by two, range 1 by four; default 1.
// - Loop enable 1 feeds dividers from the VCO; this is the default.
// - Loop enable 0 feeds the selected reference to the dividers.
// - Bypass path is edge driven and static, no minimum frequency.
// - Stop bit forces true outputs low and complements high.
// - Bank A divides VCO by 8,4,8,4 or 16,8,16,8.
// - Bank B divides VCO by 12,8,20,12 or 24,16,40,24.
// - Feedback divides VCO by 48,32,80,48 or 96,64,160,96.
// - Bank A to B ratios 3:2, 2:1, 5:2, 3:1 in any range.
// - Sync generator watches both banks for coincident edges.
// - Four bank A pairs, three bank B pairs, one sync pair.
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module pcdc_top
    import pcdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Reference and VCO
    input wire logic ref_clk_p_i,
    input wire logic ref_clk_n_i,
    input wire logic crystal_input_i,
    input wire logic vco_clk_i,
    // Generated clocks
    output logic [3:0] bank_a_outputs_p_o,
    output logic [3:0] bank_a_outputs_n_o,
    output logic [2:0] bank_b_outputs_p_o,
    output logic [2:0] bank_b_outputs_n_o,
    output logic coincidence_output_p_o,
    output logic coincidence_output_n_o,
    // Phase detector side
    output logic pll_ref_clk_o,
    output logic pll_feedback_clk_o
);

    typedef enum logic [1:0] {
        ST_STOP = 2'b01,
        ST_RUN = 2'b10
    } pcdc_run_type;

    // Register select decode shared by read and write paths
    function automatic logic [2:0] reg_decode(input logic [7:0] addr);
        logic [2:0] sel;
        sel = 3'h0;
        if (addr == ADDR_CTRL) begin
            sel[0] = 1'b1;
        end
        if (addr == ADDR_STATUS) begin
            sel[1] = 1'b1;
        end
        if (addr == ADDR_COINC_COUNT) begin
            sel[2] = 1'b1;
        end
        return sel;
    endfunction

    // Table index: bit0 is the high index bit
    function automatic logic [1:0] cfg_index(input pcdc_cfg_type cfg);
        return {cfg[0], cfg[1]};
    endfunction

    pcdc_div_if if_a ();
    pcdc_div_if if_b ();
    pcdc_div_if if_fb ();

    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [31:0] coinc_cnt_r;
    logic [31:0] coinc_cnt_nxt;
    logic [31:0] status_val;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [2:0] wr_sel;
    logic [2:0] rd_sel;
    logic addr_phase;
    pcdc_run_type run_state_r;
    logic stopped;
    logic ref_lvl;
    logic src_lvl;
    logic src_r;
    logic src_tick;
    logic [1:0] pre_cnt_r;
    logic [1:0] pre_last;
    logic div_tick;
    logic [1:0] idx;
    logic sync_lvl;
    logic coinc;
    logic [3:0] bank_a_p_r;
    logic [3:0] bank_a_n_r;
    logic [2:0] bank_b_p_r;
    logic [2:0] bank_b_n_r;
    logic qs_p_r;
    logic qs_n_r;
    logic ref_out_r;
    logic fb_out_r;

    // Bus decode
    assign addr_phase = hsel_i & hready_i & htrans_i[1];
    assign wr_sel = wr_pend_r ? reg_decode(wr_addr_r) : 3'h0;
    assign rd_sel = reg_decode(haddr_i[7:0]);

    // Pending write is applied here so a following read sees it
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_sel[0]) begin
            ctrl_nxt = hwdata_i & CTRL_MASK;
        end
    end

    // Count write clears, but a coincidence in that cycle still counts
    always_comb begin
        coinc_cnt_nxt = coinc_cnt_r;
        if (wr_sel[2]) begin
            coinc_cnt_nxt = 32'h0000_0000;
        end
        if (coinc && !stopped) begin
            coinc_cnt_nxt = coinc_cnt_nxt + 32'h0000_0001;
        end
    end

    always_comb begin
        status_val = 32'h0000_0000;
        status_val[STAT_RUN_BIT] = ~stopped;
        status_val[STAT_A_BIT] = if_a.level;
        status_val[STAT_B_BIT] = if_b.level;
        status_val[STAT_SYNC_BIT] = sync_lvl;
        status_val[STAT_FB_BIT] = if_fb.level;
        status_val[STAT_REF_BIT] = ref_lvl;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (addr_phase) begin
            // Only whole-word writes change state
            wr_pend_r <= hwrite_i & (hsize_i == HSIZE_WORD);
            wr_addr_r <= haddr_i[7:0];
        end else begin
            wr_pend_r <= 1'b0;
        end
    end

    // Read data registered at the address phase; unmapped reads zero
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hrdata_r <= 32'h0000_0000;
        end else if (addr_phase && !hwrite_i) begin
            hrdata_r <= ({32{rd_sel[0]}} & ctrl_nxt) |
                        ({32{rd_sel[1]}} & status_val) |
                        ({32{rd_sel[2]}} & coinc_cnt_nxt);
        end else begin
            hrdata_r <= 32'h0000_0000;
        end
    end

    // No wait states, always OKAY
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            coinc_cnt_r <= 32'h0000_0000;
        end else begin
            coinc_cnt_r <= coinc_cnt_nxt;
        end
    end

    // Run control; the stop bit is the device reset
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_state_r <= ST_STOP;
        end else begin
            unique case (run_state_r)
                ST_STOP: begin
                    if (!ctrl_r[CTRL_STOP_BIT]) begin
                        run_state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (ctrl_r[CTRL_STOP_BIT]) begin
                        run_state_r <= ST_STOP;
                    end
                end
                default: begin
                    run_state_r <= ST_STOP;
                end
            endcase
        end
    end

    assign stopped = (run_state_r != ST_RUN);

    // Reference and divider source selection
    assign ref_lvl = ctrl_r[CTRL_REF_SEL_BIT] ? crystal_input_i
                   : (ref_clk_p_i & ~ref_clk_n_i);
    assign src_lvl = ctrl_r[CTRL_LOOP_EN_BIT] ? vco_clk_i
                   : ref_lvl;

    // Edge detect needs no minimum rate, so bypass stays static
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            src_r <= 1'b0;
        end else begin
            src_r <= src_lvl;
        end
    end

    assign src_tick = src_lvl & ~src_r;

    // Range prescaler shared by all three dividers
    assign pre_last = ctrl_r[CTRL_VCO_RANGE_BIT] ? PRE_LAST_RANGE1
                    : PRE_LAST_RANGE0;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_cnt_r <= 2'h0;
        end else if (stopped) begin
            pre_cnt_r <= 2'h0;
        end else if (src_tick) begin
            pre_cnt_r <= (pre_cnt_r == pre_last) ? 2'h0 : pre_cnt_r + 2'h1;
        end
    end

    assign div_tick = ~stopped & src_tick & (pre_cnt_r == pre_last);

    // Divider programming; a new code takes effect at each divider's
    // next terminal count, so stop and restart to realign the banks
    assign idx = cfg_index(ctrl_r[CTRL_CFG_LSB +: 2]);

    assign if_a.tick = div_tick;
    assign if_a.clear = stopped;
    assign if_a.half = HALF_A[idx];
    assign if_b.tick = div_tick;
    assign if_b.clear = stopped;
    assign if_b.half = HALF_B[idx];
    assign if_fb.tick = div_tick;
    assign if_fb.clear = stopped;
    assign if_fb.half = HALF_FB[idx];

    pcdc_div u_div_a (
        .clk_sys_i (clk_sys_i),
        .rst_b_i (rst_b_i),
        .dv (if_a)
    );

    pcdc_div u_div_b (
        .clk_sys_i (clk_sys_i),
        .rst_b_i (rst_b_i),
        .dv (if_b)
    );

    pcdc_div u_div_fb (
        .clk_sys_i (clk_sys_i),
        .rst_b_i (rst_b_i),
        .dv (if_fb)
    );

    pcdc_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_b_i (rst_b_i),
        .bank_a (if_a),
        .bank_b (if_b),
        .clear_i (stopped),
        .period_i (SYNC_PERIODS[idx]),
        .sync_o (sync_lvl),
        .coinc_o (coinc)
    );

    // Output stage: one register delay on every pair keeps skew equal
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bank_a_p_r <= 4'h0;
            bank_a_n_r <= 4'hf;
        end else if (stopped) begin
            bank_a_p_r <= 4'h0;
            bank_a_n_r <= 4'hf;
        end else begin
            bank_a_p_r <= {4{if_a.level}};
            bank_a_n_r <= {4{~if_a.level}};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bank_b_p_r <= 3'h0;
            bank_b_n_r <= 3'h7;
        end else if (stopped) begin
            bank_b_p_r <= 3'h0;
            bank_b_n_r <= 3'h7;
        end else begin
            bank_b_p_r <= {3{if_b.level}};
            bank_b_n_r <= {3{~if_b.level}};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            qs_p_r <= 1'b0;
            qs_n_r <= 1'b1;
        end else if (stopped) begin
            qs_p_r <= 1'b0;
            qs_n_r <= 1'b1;
        end else begin
            qs_p_r <= sync_lvl;
            qs_n_r <= ~sync_lvl;
        end
    end

    // Phase detector taps; reference keeps running through stop
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_out_r <= 1'b0;
            fb_out_r <= 1'b0;
        end else begin
            ref_out_r <= ref_lvl;
            fb_out_r <= ~stopped & if_fb.level;
        end
    end

    assign hrdata_o = hrdata_r;
    assign hreadyout_o = hreadyout_r;
    assign hresp_o = hresp_r;
    assign bank_a_outputs_p_o = bank_a_p_r;
    assign bank_a_outputs_n_o = bank_a_n_r;
    assign bank_b_outputs_p_o = bank_b_p_r;
    assign bank_b_outputs_n_o = bank_b_n_r;
    assign coincidence_output_p_o = qs_p_r;
    assign coincidence_output_n_o = qs_n_r;
    assign pll_ref_clk_o = ref_out_r;
    assign pll_feedback_clk_o = fb_out_r;

endmodule

// ---- sim/pcdc_ref_model.sv ----
// Board model: free running VCO, interruptible reference sources.
// Assumes each half period is at least one system clock.
`timescale 1ns/1ps
module pcdc_ref_model #(
    parameter int VCO_HALF = 2,
    parameter int XTAL_HALF = 3,
    parameter int DIFF_HALF = 5
) (
    // Clock and control
    input wire logic clk_sys_i,
    input wire logic ref_run_i,
    // Sources
    output logic ref_clk_p_o,
    output logic ref_clk_n_o,
    output logic crystal_o,
    output logic vco_o
);
    int vc = 0;
    int rc = 0;

    initial begin
        {ref_clk_p_o, crystal_o, vco_o} = 3'h0;
        ref_clk_n_o = 1'b1;
    end

    // Interruption freezes the references at their last level
    always @(posedge clk_sys_i) begin
        vc <= vc + 1;
        vco_o <= 1'((vc / VCO_HALF) % 2);
        if (ref_run_i) begin
            rc <= rc + 1;
            crystal_o <= 1'((rc / XTAL_HALF) % 2);
            ref_clk_p_o <= 1'((rc / DIFF_HALF) % 2);
            ref_clk_n_o <= ~1'((rc / DIFF_HALF) % 2);
        end
    end
endmodule

// ---- sim/pcdc_top_sva.sv ----
// Checker for the clock divider control top, ports only.
// Assumes the bench ties hready_i to hreadyout_o.
`timescale 1ns/1ps
module pcdc_top_sva
    import pcdc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Clocks out
    input wire logic [3:0] bank_a_outputs_p_o,
    input wire logic [3:0] bank_a_outputs_n_o,
    input wire logic [2:0] bank_b_outputs_p_o,
    input wire logic [2:0] bank_b_outputs_n_o,
    input wire logic coincidence_output_p_o,
    input wire logic coincidence_output_n_o,
    input wire logic pll_feedback_clk_o
);
    logic take_w, wr_ctrl_r, rd_dp_r, stop_r;

    assign take_w = hsel_i & hready_i & htrans_i[1];

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ctrl_r <= 1'b0;
            rd_dp_r <= 1'b0;
        end else begin
            wr_ctrl_r <= take_w & hwrite_i & (haddr_i[7:0] == ADDR_CTRL)
                & (hsize_i == HSIZE_WORD);
            rd_dp_r <= take_w & ~hwrite_i;
        end
    end

    // Mirror of the stop bit, landing on the same edge as the register
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stop_r <= 1'b0;
        end else if (wr_ctrl_r & hready_i) begin
            stop_r <= hwdata_i[CTRL_STOP_BIT];
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    a_resp_okay: assert property (hresp_o == 1'b0)
        else $error("bus response not okay");
    a_ready_high: assert property (hreadyout_o == 1'b1)
        else $error("wait state inserted");
    a_rdata_idle: assert property (!rd_dp_r |-> hrdata_o == 32'h0)
        else $error("read data outside read data phase");
    a_pair_a: assert property (
        bank_a_outputs_n_o == ~bank_a_outputs_p_o)
        else $error("bank a pair not complementary");
    a_pair_b: assert property (
        bank_b_outputs_n_o == ~bank_b_outputs_p_o)
        else $error("bank b pair not complementary");
    a_pair_sync: assert property (
        coincidence_output_n_o == ~coincidence_output_p_o)
        else $error("sync pair not complementary");
    a_banks_equal: assert property (
        bank_a_outputs_p_o inside {4'h0, 4'hf}
        && bank_b_outputs_p_o inside {3'h0, 3'h7})
        else $error("bank outputs differ within a bank");
    a_stop_quiet: assert property (stop_r [*3] |->
        bank_a_outputs_p_o == 4'h0 && bank_b_outputs_p_o == 3'h0
        && !coincidence_output_p_o && !pll_feedback_clk_o)
        else $error("outputs running while stopped");
    a_sync_end: assert property (
        $fell(coincidence_output_p_o) && !stop_r
        |-> $rose(bank_a_outputs_p_o[0]) && $rose(bank_b_outputs_p_o[0]))
        else $error("sync ended off a coincident rise");
    a_sync_start: assert property (
        $rose(coincidence_output_p_o) |-> $rose(bank_a_outputs_p_o[0]))
        else $error("sync started off a bank a rise");

    c_sync: cover property ($rose(coincidence_output_p_o));
    c_stop: cover property (stop_r [*3]);
    c_read: cover property (rd_dp_r && hrdata_o != 32'h0);
endmodule

bind pcdc_top pcdc_top_sva pcdc_top_sva_i (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .bank_a_outputs_p_o(bank_a_outputs_p_o),
    .bank_a_outputs_n_o(bank_a_outputs_n_o),
    .bank_b_outputs_p_o(bank_b_outputs_p_o),
    .bank_b_outputs_n_o(bank_b_outputs_n_o),
    .coincidence_output_p_o(coincidence_output_p_o),
    .coincidence_output_n_o(coincidence_output_n_o),
    .pll_feedback_clk_o(pll_feedback_clk_o));

// ---- sim/pcdc_top_tb.sv ----
// Self-checking bench for the clock divider control top.
// Assumes the board model supplies the VCO and both references.
`timescale 1ns/1ps
module pcdc_top_tb;
    import pcdc_pkg::*;
    localparam int VH = 2;
    localparam int XH = 3;
    localparam int DH = 5;
    localparam int DA [4] = '{8, 4, 8, 4};
    localparam int DB [4] = '{12, 8, 20, 12};
    localparam int DF [4] = '{48, 32, 80, 48};
    localparam int KN [4] = '{3, 2, 5, 3};
    localparam int KD [4] = '{2, 1, 2, 1};

    logic clk, rst_b, hsel, hwrite, rd_dp, ref_run;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, r;
    wire logic hready;
    logic ref_p, ref_n, xtal, vco, sy_p, sy_n, fb, pr;
    logic [3:0] a_p, a_n;
    logic [2:0] b_p, b_n;
    logic [31:0] exp_q [$];
    int err_total = 0;
    int cmp_count = 0;

    pcdc_top pcdc_top_i (.clk_sys_i(clk), .rst_b_i(rst_b), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
        .ref_clk_p_i(ref_p), .ref_clk_n_i(ref_n), .crystal_input_i(xtal),
        .vco_clk_i(vco), .bank_a_outputs_p_o(a_p), .bank_a_outputs_n_o(a_n),
        .bank_b_outputs_p_o(b_p), .bank_b_outputs_n_o(b_n),
        .coincidence_output_p_o(sy_p), .coincidence_output_n_o(sy_n),
        .pll_ref_clk_o(pr), .pll_feedback_clk_o(fb));

    pcdc_ref_model #(.VCO_HALF(VH), .XTAL_HALF(XH), .DIFF_HALF(DH))
        pcdc_ref_model_i (.clk_sys_i(clk), .ref_run_i(ref_run),
        .ref_clk_p_o(ref_p), .ref_clk_n_o(ref_n), .crystal_o(xtal),
        .vco_o(vco));

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d,
                       logic [2:0] sz, logic [31:0] e);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= 32'(a);
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= sz;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= ~wr;
        if (!wr) exp_q.push_back(e);
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd_dp <= 1'b0;
        hsel <= 1'b0;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d, HSIZE_WORD, 32'h0);
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0, HSIZE_WORD, e);
    endtask

    // Read results are judged where they appear, oldest note first
    always @(posedge clk) begin
        if (rd_dp === 1'b1 && hready === 1'b1) begin
            check("hrdata", hrdata, exp_q.pop_front());
        end
    end

    function automatic logic sig(int s);
        case (s)
            0: return a_p[0];
            1: return b_p[0];
            2: return fb;
            default: return sy_p;
        endcase
    endfunction

    task automatic wait_rise(int s);
        logic p;
        p = sig(s);
        @(posedge clk);
        while (!(p === 1'b0 && sig(s) === 1'b1)) begin
            p = sig(s);
            @(posedge clk);
        end
    endtask

    task automatic measure(int s, output int per, output int hi);
        logic p;
        wait_rise(s);
        per = 0;
        hi = 0;
        do begin
            if (sig(s) === 1'b1) hi++;
            per++;
            p = sig(s);
            @(posedge clk);
        end while (!(p === 1'b0 && sig(s) === 1'b1));
    endtask

    // Index i is {bit0, bit1}; bit0 sits at ctrl[4], bit1 at ctrl[5]
    task automatic run(logic lp, logic rs, logic rg, logic [1:0] i);
        logic [31:0] c;
        int p, m, pa, pb, pf, ps, hs, hi;
        c = {26'h0, i[0], i[1], 1'b1, lp, rg, rs};
        p = lp ? 2 * VH : (rs ? 2 * XH : 2 * DH);
        m = rg ? 2 : 1;
        wr(ADDR_CTRL, c);
        // Cleared while stopped: the restart's first coincidence makes 1
        wr(ADDR_COINC_COUNT, $urandom);
        repeat (p) @(posedge clk);
        wr(ADDR_CTRL, c & ~32'h8);
        wait_rise(0);
        check("b_with_a", 32'(b_p[0]), 32'h1);
        rd(ADDR_COINC_COUNT, 32'h1);
        measure(0, pa, hi);
        measure(1, pb, hi);
        measure(2, pf, hi);
        measure(3, ps, hs);
        check("a_per", 32'(pa), 32'(DA[i] * m * p));
        check("b_per", 32'(pb), 32'(DB[i] * m * p));
        check("fb_per", 32'(pf), 32'(DF[i] * m * p));
        check("ratio", 32'(pb * KD[i]), 32'(pa * KN[i]));
        check("sync_per", 32'(ps), 32'(pa * KN[i]));
        check("sync_hi", 32'(hs), 32'(pa));
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    initial begin
        {hsel, hwrite, rd_dp, rst_b} = 4'h0;
        ref_run = 1'b1;
        htrans = 2'h0;
        hsize = HSIZE_WORD;
        haddr = 32'h0;
        hwdata = 32'h0;
        void'($urandom(32'h31bef4ba));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(8'h10, 32'h0);
        r = $urandom | 32'h8;
        wr(ADDR_CTRL, r);
        rd(ADDR_CTRL, r & CTRL_MASK);
        check("stopped", 32'({a_p, a_n, b_p, b_n, sy_p, sy_n, fb}),
              32'({4'h0, 4'hf, 3'h0, 3'h7, 1'b0, 1'b1, 1'b0}));
        bus(1'b1, ADDR_CTRL, 32'h0, 3'h0, 32'h0);
        rd(ADDR_CTRL, r & CTRL_MASK);
        for (int g = 0; g < 2; g++) begin
            for (int i = 0; i < 4; i++) begin
                run(1'b1, 1'b1, 1'(g), 2'(i));
            end
        end
        run(1'b0, 1'b0, 1'b0, 2'($urandom % 4));
        run(1'b0, 1'b1, 1'b1, 2'($urandom % 4));
        // Frozen reference gives a known status word and tap level
        ref_run <= 1'b0;
        wr(ADDR_CTRL, 32'h8);
        repeat (40) @(posedge clk);
        rd(ADDR_STATUS, {26'h0, ref_p & ~ref_n, 5'h0});
        check("ref_tap", 32'(pr), 32'(ref_p & ~ref_n));
        ref_run <= 1'b1;
        run(1'b0, 1'b0, 1'b1, 2'($urandom % 4));
        give_verdict();
    end
endmodule
